/* File: rtl/irhc_top.sv */
// irhc_top: input routing table and home switch position capture
// assumes: object access port driven by the fieldbus object handler,
// inputs synchronous to clk except homeSwitch, which is resynchronised
//
// Function
// RULE1: status bit k takes its source from selector entry k+1.
// RULE2: plain codes give zero, inputs 1-16, Hall, encoder, link status; 0x80 gives one.
// RULE3: codes 0x81-0x90 give inverted physical inputs 1 to 16.
// RULE4: codes 0xC1-0xC8 give inverted Hall, encoder and link status; code 0xC7 gives zero here.
// RULE5: when enabled, capture position on selected home switch level change.
// RULE6: control 0 off, 1 rising, 2 falling, 3 both edges.
// RULE7: count captured edges; writing control 1, 2 or 3 clears count.
// RULE8: each capture stores actual position in user units.
// RULE9: each capture also stores the raw sensor position.
// RULE10: master should keep capture disabled while homing runs.
// RULE11: thirty-six eight-bit selector entries, all reset to zero.
// RULE12: selectors drive the status word only while routing is enabled.
// RULE13: home switch synchronised; count and positions update on edge cycle.
`timescale 1ns/1ps
module irhc_top
   import irhc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   // object access
   input  wire logic        objWrEn,
   input  wire logic        objRdEn,
   input  wire logic [15:0] objIndex,
   input  wire logic [7:0]  objSub,
   input  wire logic [31:0] objWrData,
   output logic [31:0]      objRdData,
   output logic             objRdValid,
   output logic             objRdErr,
   // signal sources
   input  wire logic [15:0] physIn,
   input  wire logic [2:0]  hall,
   input  wire logic [2:0]  enc,
   input  wire logic        linkActive,
   input  wire logic        routingEnable,
   // home capture
   input  wire logic        homeSwitch,
   input  wire logic [31:0] actualPosition,
   input  wire logic [31:0] rawPosition,
   // result
   output logic [35:0]      inputStatusWord,
   output logic             captureEvent
);

   // ***************************************************
   // object address decode
   // ***************************************************
   logic       selRoute;
   logic       selCap;
   logic       routeEntryHit;
   logic [5:0] routeIdx;
   logic       wrRouteEntry;
   logic       wrCapCtrl;
   logic       wrCapCount;
   logic       wrCapPosUser;
   logic       wrCapPosRaw;
   logic       ctrlStart;

   assign selRoute      = (objIndex == OBJ_ROUTE_TABLE);
   assign selCap        = (objIndex == OBJ_HOME_CAPTURE);
   assign routeEntryHit = selRoute && (objSub >= SUB_ROUTE_FIRST)
                          && (objSub <= SUB_ROUTE_LAST);
   assign routeIdx      = 6'(objSub - SUB_ROUTE_FIRST);                     // RULE1
   assign wrRouteEntry  = objWrEn && routeEntryHit;
   assign wrCapCtrl     = objWrEn && selCap && (objSub == SUB_CAP_CONTROL);
   assign wrCapCount    = objWrEn && selCap && (objSub == SUB_CAP_COUNT);
   assign wrCapPosUser  = objWrEn && selCap && (objSub == SUB_CAP_POS_USER);
   assign wrCapPosRaw   = objWrEn && selCap && (objSub == SUB_CAP_POS_RAW);
   assign ctrlStart     = wrCapCtrl && (objWrData != CAP_WORD_RESET)
                          && (objWrData <= CAP_CTRL_MAX);                   // RULE7

   // ***************************************************
   // routing selector table
   // ***************************************************
   logic [7:0] routeSel_q [ROUTE_ENTRIES];

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int i = 0; i < ROUTE_ENTRIES; i++) begin
            routeSel_q[i] <= ROUTE_SEL_RESET;                               // RULE11
         end
      end else if (wrRouteEntry) begin
         routeSel_q[routeIdx] <= objWrData[7:0];                            // RULE11
      end
   end

   // ***************************************************
   // per-bit source selection
   // ***************************************************
   logic [35:0] routedWord;
   logic [35:0] plainWord;
   logic [35:0] statusWord_d;
   logic [35:0] statusWord_q;

   for (genvar k = 0; k < ROUTE_ENTRIES; k++) begin : g_route
      irhc_src_mux u_mux (
         .sel        (routeSel_q[k]),
         .physIn     (physIn),
         .hall       (hall),
         .enc        (enc),
         .linkActive (linkActive),
         .srcBit     (routedWord[k])                                        // RULE1
      );
   end

   // without routing the physical inputs sit in the low bits directly
   assign plainWord    = {20'h0_0000, physIn};
   assign statusWord_d = routingEnable ? routedWord : plainWord;            // RULE12

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         statusWord_q <= 36'h0_0000_0000;
      end else begin
         statusWord_q <= statusWord_d;
      end
   end

   assign inputStatusWord = statusWord_q;

   // ***************************************************
   // home switch synchroniser and edge detect
   // ***************************************************
   logic homeMeta_q;
   logic homeSync_q;
   logic homePrev_q;
   logic riseSeen;
   logic fallSeen;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         homeMeta_q <= 1'b0;
         homeSync_q <= 1'b0;
         homePrev_q <= 1'b0;
      end else begin
         homeMeta_q <= homeSwitch;                                          // RULE13
         homeSync_q <= homeMeta_q;                                          // RULE13
         homePrev_q <= homeSync_q;
      end
   end

   assign riseSeen = homeSync_q && !homePrev_q;
   assign fallSeen = !homeSync_q && homePrev_q;

   // ***************************************************
   // capture control
   // ***************************************************
   irhc_cap_mode_e capMode_q;
   logic [31:0]    capCtrl_q;
   logic           capHit;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         capCtrl_q <= CAP_WORD_RESET;
      end else if (wrCapCtrl) begin
         capCtrl_q <= objWrData;
      end
   end

   // out-of-range control values leave capture disabled
   assign capMode_q = (capCtrl_q <= CAP_CTRL_MAX) ? irhc_cap_mode_e'(capCtrl_q[1:0])
                                                 : CAP_OFF;

   always_comb begin
      unique case (capMode_q)
         CAP_OFF:     capHit = 1'b0;                                        // RULE6
         CAP_RISING:  capHit = riseSeen;                                    // RULE6
         CAP_FALLING: capHit = fallSeen;                                    // RULE6
         CAP_BOTH:    capHit = riseSeen || fallSeen;                        // RULE6
      endcase
   end

   // the master is expected not to enable this during homing            RULE10

   // ***************************************************
   // capture count and positions
   // ***************************************************
   logic [31:0] capCount_d;
   logic [31:0] capCount_q;
   logic [31:0] capPosUser_q;
   logic [31:0] capPosRaw_q;
   logic [31:0] countBase;
   logic        capEvent_q;

   // a capture in the clearing cycle still counts, on top of zero
   assign countBase  = ctrlStart ? CAP_WORD_RESET
                     : (wrCapCount ? objWrData : capCount_q);               // RULE7
   assign capCount_d = capHit ? countBase + 32'h0000_0001 : countBase;      // RULE7

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         capCount_q <= CAP_WORD_RESET;
      end else begin
         capCount_q <= capCount_d;                                          // RULE13
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         capPosUser_q <= CAP_WORD_RESET;
      end else if (capHit) begin
         capPosUser_q <= actualPosition;                                    // RULE5 RULE8
      end else if (wrCapPosUser) begin
         capPosUser_q <= objWrData;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         capPosRaw_q <= CAP_WORD_RESET;
      end else if (capHit) begin
         capPosRaw_q <= rawPosition;                                        // RULE5 RULE9
      end else if (wrCapPosRaw) begin
         capPosRaw_q <= objWrData;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         capEvent_q <= 1'b0;
      end else begin
         capEvent_q <= capHit;
      end
   end

   assign captureEvent = capEvent_q;

   // ***************************************************
   // object read path
   // ***************************************************
   logic [31:0] rdData_d;
   logic        rdHit_d;
   logic [31:0] rdData_q;
   logic        rdValid_q;
   logic        rdErr_q;

   always_comb begin
      rdData_d = 32'h0000_0000;
      rdHit_d  = 1'b1;
      if (selRoute && objSub == SUB_HIGHEST) begin
         rdData_d = {24'h00_0000, ROUTE_HIGHEST_VAL};
      end else if (routeEntryHit) begin
         rdData_d = {24'h00_0000, routeSel_q[routeIdx]};
      end else if (selCap && objSub == SUB_HIGHEST) begin
         rdData_d = {24'h00_0000, CAP_HIGHEST_VAL};
      end else if (selCap && objSub == SUB_CAP_CONTROL) begin
         rdData_d = capCtrl_q;
      end else if (selCap && objSub == SUB_CAP_COUNT) begin
         rdData_d = capCount_q;
      end else if (selCap && objSub == SUB_CAP_POS_USER) begin
         rdData_d = capPosUser_q;
      end else if (selCap && objSub == SUB_CAP_POS_RAW) begin
         rdData_d = capPosRaw_q;
      end else begin
         rdHit_d = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdData_q  <= 32'h0000_0000;
         rdValid_q <= 1'b0;
         rdErr_q   <= 1'b0;
      end else begin
         rdValid_q <= objRdEn;
         rdErr_q   <= objRdEn && !rdHit_d;
         if (objRdEn) begin
            rdData_q <= rdData_d;
         end
      end
   end

   assign objRdData  = rdData_q;
   assign objRdValid = rdValid_q;
   assign objRdErr   = rdErr_q;

endmodule

/* File: rtl/irhc_pkg.sv */
// irhc_pkg: constants for the input routing and home capture unit
// assumes: used by irhc_src_mux and irhc_top, single clock domain
package irhc_pkg;

   // ***************************************************
   // object indices and entries
   // ***************************************************
   localparam logic [15:0] OBJ_ROUTE_TABLE   = 16'h3242;
   localparam logic [15:0] OBJ_HOME_CAPTURE  = 16'h3243;

   localparam logic [7:0]  SUB_HIGHEST       = 8'h00;
   localparam logic [7:0]  SUB_ROUTE_FIRST   = 8'h01;
   localparam logic [7:0]  SUB_ROUTE_LAST    = 8'h24;
   localparam logic [7:0]  SUB_CAP_CONTROL   = 8'h01;
   localparam logic [7:0]  SUB_CAP_COUNT     = 8'h02;
   localparam logic [7:0]  SUB_CAP_POS_USER  = 8'h03;
   localparam logic [7:0]  SUB_CAP_POS_RAW   = 8'h04;

   // ***************************************************
   // sizes and reset values
   // ***************************************************
   localparam int          ROUTE_ENTRIES     = 36;
   localparam int          PHYS_INPUTS       = 16;
   localparam logic [7:0]  ROUTE_HIGHEST_VAL = 8'h24;
   localparam logic [7:0]  CAP_HIGHEST_VAL   = 8'h04;
   localparam logic [7:0]  ROUTE_SEL_RESET   = 8'h00;
   localparam logic [31:0] CAP_WORD_RESET    = 32'h0000_0000;

   // ***************************************************
   // selector codes (bit 7 inverts the base source)
   // ***************************************************
   localparam int          SEL_INV_BIT       = 7;
   localparam logic [6:0]  SEL_CONST_ZERO    = 7'h00;
   localparam logic [6:0]  SEL_PHYS_FIRST    = 7'h01;
   localparam logic [6:0]  SEL_PHYS_LAST     = 7'h10;
   localparam logic [6:0]  SEL_HALL_U        = 7'h41;
   localparam logic [6:0]  SEL_HALL_V        = 7'h42;
   localparam logic [6:0]  SEL_HALL_W        = 7'h43;
   localparam logic [6:0]  SEL_ENC_A         = 7'h44;
   localparam logic [6:0]  SEL_ENC_B         = 7'h45;
   localparam logic [6:0]  SEL_ENC_INDEX     = 7'h46;
   localparam logic [6:0]  SEL_LINK_ACTIVE   = 7'h48;

   // ***************************************************
   // capture edge control
   // ***************************************************
   typedef enum logic [1:0] {
      CAP_OFF     = 2'b00,
      CAP_RISING  = 2'b01,
      CAP_FALLING = 2'b10,
      CAP_BOTH    = 2'b11
   } irhc_cap_mode_e;

   localparam logic [31:0] CAP_CTRL_MAX      = 32'h0000_0003;

endpackage

/* File: rtl/irhc_src_mux.sv */
// irhc_src_mux: picks one source bit for one bit of the input status word
// assumes: all sources are synchronous to the parent clock
`timescale 1ns/1ps
module irhc_src_mux
   import irhc_pkg::*;
(
   input  wire logic [7:0]  sel,
   input  wire logic [15:0] physIn,
   input  wire logic [2:0]  hall,
   input  wire logic [2:0]  enc,
   input  wire logic        linkActive,
   output logic             srcBit
);

   // ***************************************************
   // base source decode
   // ***************************************************
   logic [6:0] baseCode;
   logic       invert;
   logic       baseBit;
   logic       baseValid;
   logic [3:0] physIdx;

   assign baseCode = sel[6:0];
   assign invert   = sel[SEL_INV_BIT];
   assign physIdx  = 4'(baseCode - SEL_PHYS_FIRST);

   always_comb begin
      baseValid = 1'b1;
      baseBit   = 1'b0;
      if (baseCode == SEL_CONST_ZERO) begin                                 // RULE2
         baseBit = 1'b0;
      end else if (baseCode >= SEL_PHYS_FIRST && baseCode <= SEL_PHYS_LAST) begin
         baseBit = physIn[physIdx];                                         // RULE2
      end else if (baseCode == SEL_HALL_U) begin
         baseBit = hall[0];
      end else if (baseCode == SEL_HALL_V) begin
         baseBit = hall[1];
      end else if (baseCode == SEL_HALL_W) begin
         baseBit = hall[2];
      end else if (baseCode == SEL_ENC_A) begin
         baseBit = enc[0];
      end else if (baseCode == SEL_ENC_B) begin
         baseBit = enc[1];
      end else if (baseCode == SEL_ENC_INDEX) begin
         baseBit = enc[2];
      end else if (baseCode == SEL_LINK_ACTIVE) begin
         baseBit = linkActive;
      end else begin
         baseValid = 1'b0;
      end
   end

   // ***************************************************
   // inversion; 0x80 is inverted zero, i.e. constant one
   // ***************************************************
   assign srcBit = baseValid & (baseBit ^ invert);                          // RULE3 RULE4

endmodule

/* File: testbench/irhc_properties.sv */
// irhc_properties: port-level checks for irhc_top
// assumes: bound to irhc_top, one clock, synchronous active-low reset
`timescale 1ns/1ps
module irhc_props_chk
   import irhc_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        objWrEn,
   input wire logic        objRdEn,
   input wire logic [15:0] objIndex,
   input wire logic [7:0]  objSub,
   input wire logic [31:0] objWrData,
   input wire logic [31:0] objRdData,
   input wire logic        objRdValid,
   input wire logic        objRdErr,
   input wire logic [15:0] physIn,
   input wire logic        routingEnable,
   input wire logic        homeSwitch,
   input wire logic [35:0] inputStatusWord,
   input wire logic        captureEvent
);
   // ***************************************************
   // mirrors of entry 1 and of the capture control
   // ***************************************************
   logic [7:0]  sel1_q;
   logic [31:0] ctrl_q;
   wire         sel1Wr = objWrEn && objIndex == OBJ_ROUTE_TABLE && objSub == SUB_ROUTE_FIRST;
   wire         ctrlWr = objWrEn && objIndex == OBJ_HOME_CAPTURE && objSub == SUB_CAP_CONTROL;
   wire         capOn  = ctrl_q != 32'h0000_0000 && ctrl_q <= CAP_CTRL_MAX;
   wire         mapped = objIndex == OBJ_ROUTE_TABLE || objIndex == OBJ_HOME_CAPTURE;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sel1_q <= 8'h00;
         ctrl_q <= 32'h0000_0000;
      end else begin
         if (sel1Wr) sel1_q <= objWrData[7:0];
         if (ctrlWr) ctrl_q <= objWrData;
      end
   end
   // ***************************************************
   // properties
   // ***************************************************
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence capOffHeld;
      (!capOn) [*6];
   endsequence
   // two sync stages, one edge-detect stage, then the event register
   sequence pinChanged;
      $past(homeSwitch, 3) != $past(homeSwitch, 4);
   endsequence
   rd_answer_a: assert property (objRdEn |=> objRdValid) else $error("read not answered");
   rd_pulse_a: assert property (objRdValid |-> $past(objRdEn)) else $error("stray read valid");
   unmapped_err_a: assert property (objRdEn && !mapped |=> objRdErr && objRdData == 32'h0)
      else $error("unmapped read not refused");
   entry_read_a: assert property (objRdEn && objIndex == OBJ_ROUTE_TABLE &&
      objSub >= SUB_ROUTE_FIRST && objSub <= SUB_ROUTE_LAST |=> !objRdErr && objRdData[31:8] == 24'h0)
      else $error("selector entry read wrong");
   route_off_a: assert property (!routingEnable |=>
      inputStatusWord == {20'h0, $past(physIn)}) else $error("routing off word wrong");
   route_inv_a: assert property (routingEnable && sel1_q == 8'h81 |=>
      inputStatusWord[0] == !$past(physIn[0])) else $error("inverted input 1 wrong");
   route_one_a: assert property (routingEnable && sel1_q == 8'h80 |=>
      inputStatusWord[0]) else $error("constant one wrong");
   capture_off_a: assert property (capOffHeld |-> !captureEvent)
      else $error("capture while off");
   capture_cause_a: assert property (captureEvent |-> pinChanged)
      else $error("capture without pin change");
endmodule
bind irhc_top irhc_props_chk chk_u (
   .clk(clk), .rst_n(rst_n), .objWrEn(objWrEn), .objRdEn(objRdEn), .objIndex(objIndex),
   .objSub(objSub), .objWrData(objWrData), .objRdData(objRdData), .objRdValid(objRdValid),
   .objRdErr(objRdErr), .physIn(physIn), .routingEnable(routingEnable),
   .homeSwitch(homeSwitch), .inputStatusWord(inputStatusWord), .captureEvent(captureEvent)
);

/* File: testbench/irhc_home_model.sv */
// irhc_home_model: home switch pin and position sources
// assumes: stepReq driven by the bench off the falling edge
`timescale 1ns/1ps
module irhc_home_model (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        stepReq,
   output logic             homeSwitch,
   output logic [31:0]      actualPosition,
   output logic [31:0]      rawPosition
);
   // pin moves 17 ns after the edge, unrelated to the sampling point
   always @(posedge clk) begin
      if (!rst_n) begin
         homeSwitch <= 1'b0;
         actualPosition <= 32'h0000_1000;
         rawPosition <= 32'h0000_0040;
      end else if (stepReq) begin
         homeSwitch <= #17 ~homeSwitch;
         actualPosition <= actualPosition + 32'h0000_0123;
         rawPosition <= rawPosition + 32'h0000_0011;
      end
   end
endmodule

/* File: testbench/irhc_tb.sv */
// irhc_tb: self-checking bench for irhc_top
// assumes: irhc_home_model drives the home pin and positions
`timescale 1ns/1ps
module testbench
   import irhc_pkg::*;
;
   logic        clk, rst_n, objWrEn, objRdEn, stepReq, linkActive, routingEnable;
   logic [15:0] objIndex, physIn;
   logic [7:0]  objSub;
   logic [31:0] objWrData, objRdData, actualPosition, rawPosition;
   logic        objRdValid, objRdErr, homeSwitch, captureEvent;
   logic [2:0]  hall, enc;
   logic [35:0] inputStatusWord;
   int          failures, comparisons, events;
   logic [7:0]  codes [22] = '{8'h00, 8'h01, 8'h07, 8'h10, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45,
      8'h46, 8'h48, 8'h80, 8'h81, 8'h8a, 8'h90, 8'hc1, 8'hc2, 8'hc3, 8'hc4, 8'hc5, 8'hc6, 8'hc8};
   irhc_top dut_u (.clk(clk), .rst_n(rst_n), .objWrEn(objWrEn), .objRdEn(objRdEn),
      .objIndex(objIndex), .objSub(objSub), .objWrData(objWrData), .objRdData(objRdData),
      .objRdValid(objRdValid), .objRdErr(objRdErr), .physIn(physIn), .hall(hall), .enc(enc),
      .linkActive(linkActive), .routingEnable(routingEnable), .homeSwitch(homeSwitch),
      .actualPosition(actualPosition), .rawPosition(rawPosition),
      .inputStatusWord(inputStatusWord), .captureEvent(captureEvent));
   irhc_home_model model_u (.clk(clk), .rst_n(rst_n), .stepReq(stepReq),
      .homeSwitch(homeSwitch), .actualPosition(actualPosition), .rawPosition(rawPosition));
   always #50 clk = ~clk;
   // counts capture pulses where they are settled
   always @(negedge clk) if (captureEvent === 1'b1) events++;
   // ***************************************************
   // shared tasks
   // ***************************************************
   task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d);
      @(negedge clk);
      objWrEn = 1'b1;
      objIndex = idx;
      objSub = sub;
      objWrData = d;
      @(negedge clk);
      objWrEn = 1'b0;
   endtask
   task automatic rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp,
                     input logic err);
      @(negedge clk);
      objRdEn = 1'b1;
      objIndex = idx;
      objSub = sub;
      @(negedge clk);
      objRdEn = 1'b0;
      check("read valid", 36'h1, {35'h0, objRdValid});
      check("read error", {35'h0, err}, {35'h0, objRdErr});
      check("read data", {4'h0, exp}, {4'h0, objRdData});
   endtask
   function automatic logic pick(input logic [7:0] c);
      logic s;
      case (c[6:0])
         7'h00: s = 1'b0;
         7'h41, 7'h42, 7'h43: s = hall[c[1:0] - 2'h1];
         7'h44, 7'h45, 7'h46: s = enc[c[2:0] - 3'h4];
         7'h48: s = linkActive;
         default: s = physIn[c[3:0] - 4'h1];
      endcase
      return s ^ c[7];
   endfunction
   task automatic step_home(output logic [31:0] pu, output logic [31:0] pr);
      @(negedge clk);
      stepReq = 1'b1;
      @(negedge clk);
      stepReq = 1'b0;
      pu = actualPosition;
      pr = rawPosition;
      repeat (8) @(negedge clk);
   endtask
   // ***************************************************
   // scenarios
   // ***************************************************
   task automatic t_reset();
      rd(OBJ_HOME_CAPTURE, SUB_HIGHEST, 32'h0000_0004, 1'b0);
      rd(OBJ_ROUTE_TABLE, SUB_HIGHEST, 32'h0000_0024, 1'b0);
      rd(OBJ_ROUTE_TABLE, SUB_ROUTE_LAST, 32'h0000_0000, 1'b0);
      for (int s = 1; s < 5; s++) rd(OBJ_HOME_CAPTURE, 8'(s), 32'h0000_0000, 1'b0);
      rd(16'h3244, SUB_HIGHEST, 32'h0000_0000, 1'b1);
      rd(OBJ_ROUTE_TABLE, 8'h25, 32'h0000_0000, 1'b1);
      wr(OBJ_HOME_CAPTURE, SUB_HIGHEST, 32'h0000_0009);
      rd(OBJ_HOME_CAPTURE, SUB_HIGHEST, 32'h0000_0004, 1'b0);
   endtask
   task automatic t_route();
      for (int f = 0; f < 2; f++) begin
         @(negedge clk);
         routingEnable = 1'b1;
         physIn = (f == 1) ? 16'h5a3c : 16'ha5c3;
         hall = (f == 1) ? 3'b101 : 3'b010;
         enc = (f == 1) ? 3'b011 : 3'b100;
         linkActive = (f == 1);
         for (int i = 0; i < 22; i++) begin
            wr(OBJ_ROUTE_TABLE, SUB_ROUTE_FIRST, {24'h0, codes[i]});
            wr(OBJ_ROUTE_TABLE, SUB_ROUTE_LAST, {24'h0, codes[21 - i]});
            @(negedge clk);
            check("bit 0", {35'h0, pick(codes[i])}, {35'h0, inputStatusWord[0]});
            check("bit 35", {35'h0, pick(codes[21 - i])}, {35'h0, inputStatusWord[35]});
            check("bit 1", 36'h0, {35'h0, inputStatusWord[1]});
         end
      end
      rd(OBJ_ROUTE_TABLE, SUB_ROUTE_FIRST, {24'h0, codes[21]}, 1'b0);
      @(negedge clk);
      routingEnable = 1'b0;
      @(negedge clk);
      check("routing off", {20'h0, physIn}, inputStatusWord);
   endtask
   task automatic t_capture();
      logic [31:0] u1, r1, u2, r2;
      int          e0;
      for (int m = 1; m < 4; m++) begin
         wr(OBJ_HOME_CAPTURE, SUB_CAP_CONTROL, 32'(m));
         rd(OBJ_HOME_CAPTURE, SUB_CAP_COUNT, 32'h0000_0000, 1'b0);
         e0 = events;
         step_home(u1, r1);
         step_home(u2, r2);
         check("capture events", (m == 3) ? 36'h2 : 36'h1, 36'(events - e0));
         rd(OBJ_HOME_CAPTURE, SUB_CAP_COUNT, (m == 3) ? 32'h2 : 32'h1, 1'b0);
         rd(OBJ_HOME_CAPTURE, SUB_CAP_POS_USER, (m == 1) ? u1 : u2, 1'b0);
         rd(OBJ_HOME_CAPTURE, SUB_CAP_POS_RAW, (m == 1) ? r1 : r2, 1'b0);
      end
      wr(OBJ_HOME_CAPTURE, SUB_CAP_CONTROL, 32'h0000_0000);
      e0 = events;
      step_home(u1, r1);
      step_home(u2, r2);
      rd(OBJ_HOME_CAPTURE, SUB_CAP_COUNT, 32'h0000_0002, 1'b0);
      // out-of-range control is stored but leaves capture off
      wr(OBJ_HOME_CAPTURE, SUB_CAP_CONTROL, 32'h0000_0005);
      step_home(u1, r1);
      rd(OBJ_HOME_CAPTURE, SUB_CAP_CONTROL, 32'h0000_0005, 1'b0);
      rd(OBJ_HOME_CAPTURE, SUB_CAP_COUNT, 32'h0000_0002, 1'b0);
      check("events while off", 36'h0, 36'(events - e0));
      wr(OBJ_HOME_CAPTURE, SUB_CAP_COUNT, 32'h0000_0005);
      rd(OBJ_HOME_CAPTURE, SUB_CAP_COUNT, 32'h0000_0005, 1'b0);
   endtask
   task automatic end_of_test();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      #500000;
      failures++;
      end_of_test();
   end
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      {objWrEn, objRdEn, stepReq, linkActive, routingEnable} = 5'h00;
      {objIndex, objSub, objWrData} = 56'h0;
      {physIn, hall, enc} = 22'h0;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      t_reset();
      t_route();
      t_capture();
      end_of_test();
   end
endmodule
